// ### design/lcd_frame_address_regs.sv
// Behaviour
// - Bias rate zero: alternating bias inverts on every frame pulse.
// - Bias rate N nonzero: bias inverts after every N+1 line pulses.
// - Bias toggling applies to passive panels only.
// - First region start is 16 bits: low byte and high byte registers.
// - Landscape: first region start is a word address.
// - Rotated: first region start is a byte address, bit 16 from overflow bit 0.
// - Overflow bit ignored in landscape.
// - Second region start is a 16-bit word address in landscape.
// - Rotated mode ignores the second region start.
// - Line memory offset affects addressing only in landscape.
// - Nonzero offset adds words between consecutive lines, forming a virtual image.
// - Frame pulse position held between one and blank period inclusive.
//
// Added by the designer: the APB slave port.
`include "lcd_frame_map.svh"

module lcd_frame_address_regs
    import lcd_frame_pkg::*;
(
    input wire logic core_clk, // 50 MHz clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped index
    output panel_t panel, // Line, frame and bias to panel
    output logic [16:0] mem_line_addr, // Byte address of line start
    output logic mem_line_start, // Pulse: new displayed line
    output logic irq // Level interrupt
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    regs_t regs, next_regs;
    logic [1:0] irq_status, next_irq_status;
    logic [31:0] next_prdata;
    logic next_pslverr;
    scan_state_t state, next_state;
    logic [7:0] line_tmr, next_line_tmr;
    logic [10:0] line_cnt, next_line_cnt;
    logic [5:0] bias_cnt, next_bias_cnt;
    logic [16:0] next_mem_line_addr;
    logic next_mem_line_start;
    panel_t next_panel;
    logic next_alt_bias;

    logic [9:0] idx;
    logic wr_en;
    logic rd_setup;
    logic line_tick;
    logic [10:0] last_line;
    logic [10:0] fp_line;
    logic [5:0] fp_eff;
    logic [16:0] line_step;
    logic [1:0] events;

    assign idx = paddr[11:2];
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready = psel && penable;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_comb
    begin
        next_regs = regs;
        if (wr_en)
        begin
            case (idx)
                `IDX_FRAME_PULSE_POS: next_regs.fp_pos = pwdata[5:0];
                `IDX_VBLANK: next_regs.vblank_lines = pwdata[5:0];
                `IDX_BIAS_RATE: next_regs.bias_rate = pwdata[5:0];
                `IDX_S1_LOW: next_regs.s1_start[7:0] = pwdata[7:0];
                `IDX_S1_HIGH: next_regs.s1_start[15:8] = pwdata[7:0];
                `IDX_S2_LOW: next_regs.s2_start[7:0] = pwdata[7:0];
                `IDX_S2_HIGH: next_regs.s2_start[15:8] = pwdata[7:0];
                `IDX_S1_OVERFLOW: next_regs.s1_bit16 = pwdata[0];
                `IDX_LINE_OFFSET: next_regs.line_offset = pwdata[7:0];
                `IDX_CONTROL: next_regs.ctrl = pwdata[2:0];
                `IDX_DISP_LINES_LOW: next_regs.disp_lines[7:0] = pwdata[7:0];
                `IDX_DISP_LINES_HIGH: next_regs.disp_lines[9:8] = pwdata[1:0];
                `IDX_SPLIT_LOW: next_regs.split_line[7:0] = pwdata[7:0];
                `IDX_SPLIT_HIGH: next_regs.split_line[9:8] = pwdata[1:0];
                `IDX_LINE_LENGTH: next_regs.line_length = pwdata[7:0];
                `IDX_LINE_CYCLES: next_regs.line_cycles = pwdata[7:0];
                `IDX_IRQ_ENABLE: next_regs.irq_enable = pwdata[1:0];
                default: next_regs = regs;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read data, captured in the setup cycle so it is stable at access
    // ----------------------------------------------------------------
    always_comb
    begin
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (rd_setup)
        begin
            next_prdata = 32'h0000_0000;
            case (idx)
                `IDX_FRAME_PULSE_POS: next_prdata[5:0] = regs.fp_pos;
                `IDX_VBLANK:
                begin
                    next_prdata[5:0] = regs.vblank_lines;
                    next_prdata[`VBLANK_STATUS_BIT] = (state == SCAN_BLANK);
                end
                `IDX_BIAS_RATE: next_prdata[5:0] = regs.bias_rate;
                `IDX_S1_LOW: next_prdata[7:0] = regs.s1_start[7:0];
                `IDX_S1_HIGH: next_prdata[7:0] = regs.s1_start[15:8];
                `IDX_S2_LOW: next_prdata[7:0] = regs.s2_start[7:0];
                `IDX_S2_HIGH: next_prdata[7:0] = regs.s2_start[15:8];
                `IDX_S1_OVERFLOW: next_prdata[0] = regs.s1_bit16;
                `IDX_LINE_OFFSET: next_prdata[7:0] = regs.line_offset;
                `IDX_CONTROL: next_prdata[2:0] = regs.ctrl;
                `IDX_DISP_LINES_LOW: next_prdata[7:0] = regs.disp_lines[7:0];
                `IDX_DISP_LINES_HIGH: next_prdata[1:0] = regs.disp_lines[9:8];
                `IDX_SPLIT_LOW: next_prdata[7:0] = regs.split_line[7:0];
                `IDX_SPLIT_HIGH: next_prdata[1:0] = regs.split_line[9:8];
                `IDX_LINE_LENGTH: next_prdata[7:0] = regs.line_length;
                `IDX_LINE_CYCLES: next_prdata[7:0] = regs.line_cycles;
                `IDX_IRQ_STATUS: next_prdata[1:0] = irq_status;
                `IDX_IRQ_CLEAR: next_prdata = 32'h0000_0000;
                `IDX_IRQ_ENABLE: next_prdata[1:0] = regs.irq_enable;
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Line and frame timing
    // ----------------------------------------------------------------
    assign line_tick = regs.ctrl.enable && (line_tmr >= regs.line_cycles);
    assign last_line = {1'b0, regs.disp_lines} + {5'h00, regs.vblank_lines};

    always_comb
    begin
        fp_eff = 6'h01;
        if (regs.ctrl.active_panel && regs.fp_pos != 6'h00)
        begin
            fp_eff = (regs.fp_pos > regs.vblank_lines) ? regs.vblank_lines : regs.fp_pos;
        end
        // With no blank lines the frame pulse marks the wrap to line 0
        if (regs.vblank_lines == 6'h00)
        begin
            fp_line = 11'h000;
        end
        else
        begin
            fp_line = {1'b0, regs.disp_lines} + {5'h00, fp_eff};
        end
    end

    always_comb
    begin
        next_state = state;
        next_line_tmr = line_tmr;
        next_line_cnt = line_cnt;
        next_panel.alt_bias_out = next_alt_bias;
        next_panel.line_pulse = 1'b0;
        next_panel.frame_pulse = 1'b0;
        if (!regs.ctrl.enable)
        begin
            next_state = SCAN_IDLE;
            next_line_tmr = 8'h00;
            next_line_cnt = last_line;
        end
        else if (line_tick)
        begin
            next_line_tmr = 8'h00;
            next_panel.line_pulse = 1'b1;
            next_line_cnt = (line_cnt >= last_line) ? 11'h000 : line_cnt + 11'h001;
            next_state = (next_line_cnt > {1'b0, regs.disp_lines}) ? SCAN_BLANK : SCAN_DISPLAY;
            next_panel.frame_pulse = (next_line_cnt == fp_line);
        end
        else
        begin
            next_line_tmr = line_tmr + 8'h01;
        end
        if (state == SCAN_IDLE && regs.ctrl.enable)
        begin
            next_state = SCAN_BLANK;
        end
    end

    // ----------------------------------------------------------------
    // Alternating bias
    // ----------------------------------------------------------------
    always_comb
    begin
        next_bias_cnt = bias_cnt;
        next_alt_bias = panel.alt_bias_out;
        // Active panels have no use for bias; hold it low there
        if (!regs.ctrl.enable || regs.ctrl.active_panel)
        begin
            next_bias_cnt = 6'h00;
            next_alt_bias = 1'b0;
        end
        else if (regs.bias_rate == 6'h00)
        begin
            next_bias_cnt = 6'h00;
            if (panel.frame_pulse)
            begin
                next_alt_bias = !panel.alt_bias_out;
            end
        end
        else if (panel.line_pulse)
        begin
            if (bias_cnt >= regs.bias_rate)
            begin
                next_bias_cnt = 6'h00;
                next_alt_bias = !panel.alt_bias_out;
            end
            else
            begin
                next_bias_cnt = bias_cnt + 6'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Line start addresses
    // ----------------------------------------------------------------
    always_comb
    begin
        if (regs.ctrl.rotated_display_mode)
        begin
            line_step = {9'h000, regs.line_length};
        end
        else
        begin
            line_step = {7'h00, ({1'b0, regs.line_length} + {1'b0, regs.line_offset}), 1'b0};
        end
    end

    always_comb
    begin
        next_mem_line_addr = mem_line_addr;
        next_mem_line_start = 1'b0;
        if (line_tick && next_state == SCAN_DISPLAY)
        begin
            next_mem_line_start = 1'b1;
            if (next_line_cnt == 11'h000)
            begin
                if (regs.ctrl.rotated_display_mode)
                begin
                    next_mem_line_addr = {regs.s1_bit16, regs.s1_start};
                end
                else
                begin
                    next_mem_line_addr = {regs.s1_start, 1'b0};
                end
            end
            else if (!regs.ctrl.rotated_display_mode && (next_line_cnt == {1'b0, regs.split_line} + 11'h001))
            begin
                next_mem_line_addr = {regs.s2_start, 1'b0};
            end
            else
            begin
                next_mem_line_addr = mem_line_addr + line_step;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts: set wins over clear
    // ----------------------------------------------------------------
    assign events = {(state != SCAN_BLANK) && (next_state == SCAN_BLANK), next_panel.frame_pulse};

    always_comb
    begin
        next_irq_status = irq_status;
        if (wr_en && idx == `IDX_IRQ_CLEAR)
        begin
            next_irq_status = irq_status & ~pwdata[1:0];
        end
        next_irq_status = next_irq_status | events;
    end

    assign irq = |(irq_status & regs.irq_enable);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            regs <= '0;
            regs.disp_lines <= `RST_DISP_LINES;
            regs.split_line <= `RST_SPLIT_LINE;
            regs.line_length <= `RST_LINE_LENGTH;
            regs.line_cycles <= `RST_LINE_CYCLES;
            irq_status <= 2'h0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            state <= SCAN_IDLE;
            line_tmr <= 8'h00;
            line_cnt <= 11'h000;
            bias_cnt <= 6'h00;
            panel <= '0;
            mem_line_addr <= 17'h0_0000;
            mem_line_start <= 1'b0;
        end
        else
        begin
            regs <= next_regs;
            irq_status <= next_irq_status;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            state <= next_state;
            line_tmr <= next_line_tmr;
            line_cnt <= next_line_cnt;
            bias_cnt <= next_bias_cnt;
            panel <= next_panel;
            mem_line_addr <= next_mem_line_addr;
            mem_line_start <= next_mem_line_start;
        end
    end

endmodule

// ### design/lcd_frame_map.svh
`ifndef LCD_FRAME_MAP_SVH
`define LCD_FRAME_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_FRAME_PULSE_POS 10'h009
`define IDX_VBLANK 10'h00a
`define IDX_BIAS_RATE 10'h00b
`define IDX_S1_LOW 10'h00c
`define IDX_S1_HIGH 10'h00d
`define IDX_S2_LOW 10'h00e
`define IDX_S2_HIGH 10'h00f
`define IDX_S1_OVERFLOW 10'h010
`define IDX_LINE_OFFSET 10'h011
`define IDX_CONTROL 10'h020
`define IDX_DISP_LINES_LOW 10'h021
`define IDX_DISP_LINES_HIGH 10'h022
`define IDX_SPLIT_LOW 10'h023
`define IDX_SPLIT_HIGH 10'h024
`define IDX_LINE_LENGTH 10'h025
`define IDX_LINE_CYCLES 10'h026
`define IDX_IRQ_STATUS 10'h027
`define IDX_IRQ_CLEAR 10'h028
`define IDX_IRQ_ENABLE 10'h029

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VBLANK_STATUS_BIT 7
`define CTRL_ENABLE_BIT 0
`define CTRL_ROTATED_BIT 1
`define CTRL_ACTIVE_BIT 2
`define IRQ_FRAME_BIT 0
`define IRQ_VBLANK_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_DISP_LINES 10'h0ef
`define RST_SPLIT_LINE 10'h3ff
`define RST_LINE_LENGTH 8'h28
`define RST_LINE_CYCLES 8'h40

`endif

// ### design/lcd_frame_pkg.sv
package lcd_frame_pkg;

    typedef enum logic [1:0]
    {
        SCAN_IDLE = 2'b00,
        SCAN_DISPLAY = 2'b01,
        SCAN_BLANK = 2'b11
    } scan_state_t;

    typedef struct packed
    {
        logic active_panel;
        logic rotated_display_mode;
        logic enable;
    } ctrl_t;

    typedef struct packed
    {
        logic [5:0] vblank_lines;
        logic [5:0] bias_rate;
        logic [15:0] s1_start;
        logic [15:0] s2_start;
        logic s1_bit16;
        logic [7:0] line_offset;
        logic [5:0] fp_pos;
        ctrl_t ctrl;
        logic [9:0] disp_lines;
        logic [9:0] split_line;
        logic [7:0] line_length;
        logic [7:0] line_cycles;
        logic [1:0] irq_enable;
    } regs_t;

    typedef struct packed
    {
        logic line_pulse;
        logic frame_pulse;
        logic alt_bias_out;
    } panel_t;

endpackage

// ### tb/lcd_frame_address_regs_sva.sv
`include "lcd_frame_map.svh"

module lcd_frame_address_regs_sva
    import lcd_frame_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic srst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire panel_t panel, // Panel pulses
    input wire logic [16:0] mem_line_addr, // Line address
    input wire logic mem_line_start, // Line fetch
    input wire logic irq // Interrupt
);
    logic acc;
    logic wr_acc;
    logic mapped;
    logic [9:0] idx;
    logic passive_on;
    assign idx = paddr[11:2];
    // Bias is forced low when leaving passive mode, off any line pulse
    always_ff @(posedge core_clk)
    begin
        if (srst)
            passive_on <= 1'b0;
        else if (wr_acc && idx == `IDX_CONTROL)
            passive_on <= pwdata[`CTRL_ENABLE_BIT] && !pwdata[`CTRL_ACTIVE_BIT];
    end
    assign acc = psel && penable;
    assign wr_acc = acc && pwrite;
    assign mapped = (idx >= `IDX_FRAME_PULSE_POS && idx <= `IDX_LINE_OFFSET) ||
        (idx >= `IDX_CONTROL && idx <= `IDX_IRQ_ENABLE);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    AST_READY: assert property (pready == acc)
        else $error("ready not equal to access phase");
    AST_ERR_MAP: assert property (acc |-> pslverr == !mapped)
        else $error("error flag wrong for index");
    AST_ERR_ONLY: assert property (pslverr |-> acc)
        else $error("error flag outside access");
    AST_CLR_RD: assert property (acc && !pwrite && idx == `IDX_IRQ_CLEAR |-> prdata == 32'h0)
        else $error("clear register read not zero");
    AST_FETCH: assert property (mem_line_start |-> panel.line_pulse)
        else $error("fetch without line pulse");
    AST_FRAME_LINE: assert property (panel.frame_pulse |-> panel.line_pulse)
        else $error("frame pulse off line pulse");
    AST_BIAS: assert property ($changed(panel.alt_bias_out) && passive_on |-> $past(panel.line_pulse))
        else $error("bias moved away from line pulse");
    AST_IRQ_RISE: assert property ($rose(irq) |-> panel.line_pulse || $past(panel.line_pulse) || $past(wr_acc))
        else $error("irq rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_acc))
        else $error("irq fell without write");
    cover property (panel.frame_pulse);
    cover property ($changed(panel.alt_bias_out));
    cover property (acc && pslverr);
    cover property ($rose(irq));
endmodule

bind lcd_frame_address_regs lcd_frame_address_regs_sva lcd_frame_address_regs_sva_i (.core_clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .panel, .mem_line_addr,
    .mem_line_start, .irq);

// ### tb/lcd_frame_address_regs_tb_top.sv
`include "lcd_frame_map.svh"

module lcd_frame_address_regs_tb_top;
    import lcd_frame_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr, irq, mem_line_start, e, b16, rot;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, d, seed;
    logic [16:0] mem_line_addr;
    panel_t panel;
    logic [7:0] frame_lines, bias_gap, frame_lag, off, len;
    logic [15:0] bias_flips, f, s1, s2;
    logic [9:0] spl;
    logic [5:0] rates [4];
    logic [7:0] msk [9] = '{8'h3f, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'hff};
    int fails, cmp_count;
    lcd_frame_address_regs lcd_frame_address_regs_i (.core_clk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .panel, .mem_line_addr, .mem_line_start, .irq);
    lcd_panel_model lcd_panel_model_i (.core_clk, .srst, .panel, .line_fetch(mem_line_start),
        .frame_lines, .bias_gap, .frame_lag, .bias_flips);
    always #10 core_clk = ~core_clk;
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Split applies in landscape only; rotated steps in bytes
    function automatic logic [16:0] exp_addr(int k);
        logic [16:0] a;
        a = rot ? {b16, s1} : {s1, 1'b0};
        for (int i = 1; i <= k; i++)
            a = (!rot && i == spl + 1) ? {s2, 1'b0} : 17'(a + (rot ? len : 2 * (len + off)));
        return a;
    endfunction
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic [9:0] i, input logic w, input logic [31:0] wd, output logic [31:0] rd_v,
        output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // Answer is taken at the very edge where ready is seen high
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            fails++;
        rd_v = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [9:0] i, input logic [31:0] v);
        logic [31:0] t;
        logic er;
        apb(i, 1'b1, v, t, er);
    endtask
    task automatic rd(input logic [9:0] i, output logic [31:0] v);
        logic er;
        apb(i, 1'b0, 32'h0, v, er);
    endtask
    task automatic wait_ev(input logic fetch);
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while ((fetch ? mem_line_start : panel.frame_pulse) !== 1'b1 && n < 2000);
        if ((fetch ? mem_line_start : panel.frame_pulse) !== 1'b1)
            fails++;
        @(posedge core_clk);
    endtask
    task automatic cfg(input logic [31:0] ctl);
        wr(`IDX_S1_LOW, 32'(s1[7:0]));
        wr(`IDX_S1_HIGH, 32'(s1[15:8]));
        wr(`IDX_S2_LOW, 32'(s2[7:0]));
        wr(`IDX_S2_HIGH, 32'(s2[15:8]));
        wr(`IDX_S1_OVERFLOW, 32'(b16));
        wr(`IDX_LINE_OFFSET, 32'(off));
        wr(`IDX_SPLIT_LOW, 32'(spl[7:0]));
        wr(`IDX_SPLIT_HIGH, 32'(spl[9:8]));
        wr(`IDX_CONTROL, ctl);
    endtask
    task automatic cap_chk();
        wait_ev(1'b0);
        wait_ev(1'b0);
        for (int k = 0; k < 4; k++)
        begin
            wait_ev(1'b1);
            chk("line_addr", 32'(exp_addr(k)), 32'(mem_line_addr));
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    initial
    begin
        #(20 * 40000);
        fails++;
        print_verdict();
    end
    initial
    begin
        {core_clk, psel, penable, pwrite, paddr, pwdata} = '0;
        srst = 1'b1;
        seed = 32'h6ecc;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 9; i++)
        begin
            rd(10'h009 + 10'(i), r);
            chk("reset_val", 32'h0, r);
        end
        repeat (3)
            for (int i = 0; i < 9; i++)
            begin
                d = rnd();
                wr(10'h009 + 10'(i), d);
                rd(10'h009 + 10'(i), r);
                chk("reg_rdbk", d & {24'h0, msk[i]}, r);
            end
        apb(10'h012, 1'b1, rnd(), r, e);
        chk("slverr_wr", 32'h1, 32'(e));
        apb(10'h3ff, 1'b0, 32'h0, r, e);
        chk("slverr_rd", 32'h1, 32'(e));
        // Four displayed lines of five clocks keep frames short
        wr(`IDX_DISP_LINES_LOW, 32'h3);
        wr(`IDX_LINE_CYCLES, 32'h4);
        len = 8'h10;
        wr(`IDX_LINE_LENGTH, 32'(len));
        wr(`IDX_BIAS_RATE, 32'h0);
        s1 = 16'(rnd());
        s2 = 16'(rnd());
        off = 8'(rnd());
        b16 = 1'b1;
        spl = 10'h3ff;
        rot = 1'b0;
        cfg(32'h1);
        foreach (msk[i])
            if (i < 3)
            begin
                wr(`IDX_VBLANK, 32'(i * i + i / 2 * 3));
                wait_ev(1'b0);
                wait_ev(1'b0);
                wait_ev(1'b0);
                chk("frame_lines", 32'(4 + i * i + i / 2 * 3), 32'(frame_lines));
            end
        wait_ev(1'b0);
        rd(`IDX_VBLANK, r);
        chk("blank_flag", 32'h87, r);
        wait_ev(1'b1);
        rd(`IDX_VBLANK, r);
        chk("blank_flag", 32'h07, r);
        cap_chk();
        spl = 10'h1;
        cfg(32'h1);
        cap_chk();
        rot = 1'b1;
        cfg(32'h3);
        cap_chk();
        rot = 1'b0;
        cfg(32'h1);
        rates = '{6'h0, 6'h1, 6'h3, 6'(rnd() % 63 + 1)};
        foreach (rates[i])
        begin
            wr(`IDX_BIAS_RATE, 32'(rates[i]));
            f = bias_flips;
            for (int n = 0; n < 5000 && bias_flips < f + 16'h3; n++)
                @(posedge core_clk);
            if (bias_flips < f + 16'h3)
                fails++;
            // Rate zero: one flip per frame of four shown and seven blank lines
            chk("bias_gap", rates[i] == 0 ? 32'(4 + 7) : 32'(rates[i]) + 1, 32'(bias_gap));
        end
        wr(`IDX_CONTROL, 32'h5);
        foreach (rates[i])
            if (i < 3)
            begin
                // Zero acts as one, values past the blank period clamp to it
                d = 32'(i * 4 + i / 2 * 5);
                wr(`IDX_FRAME_PULSE_POS, d);
                wait_ev(1'b0);
                wait_ev(1'b0);
                chk("frame_lag", (d == 32'h0) ? 32'h1 : (d > 32'h7) ? 32'h7 : d, 32'(frame_lag));
            end
        chk("bias_active", 32'h0, 32'(panel.alt_bias_out));
        wr(`IDX_CONTROL, 32'h1);
        wr(`IDX_IRQ_ENABLE, 32'h0);
        wr(`IDX_IRQ_CLEAR, 32'h3);
        wait_ev(1'b0);
        chk("irq_masked", 32'h0, 32'(irq));
        rd(`IDX_IRQ_STATUS, r);
        chk("irq_status", 32'h1, r & 32'h1);
        wr(`IDX_IRQ_ENABLE, 32'h1);
        chk("irq_on", 32'h1, 32'(irq));
        wr(`IDX_IRQ_CLEAR, 32'h3);
        chk("irq_off", 32'h0, 32'(irq));
        rd(`IDX_IRQ_CLEAR, r);
        chk("clr_rd", 32'h0, r);
        rd(`IDX_IRQ_STATUS, r);
        chk("irq_cleared", 32'h0, r);
        print_verdict();
    end
endmodule

// ### tb/lcd_panel_model.sv
module lcd_panel_model
    import lcd_frame_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic srst, // Reset
    input wire panel_t panel, // Pulses from block
    input wire logic line_fetch, // Displayed line start
    output logic [7:0] frame_lines, // Lines per frame
    output logic [7:0] bias_gap, // Lines per bias phase
    output logic [7:0] frame_lag, // Lines after last fetch
    output logic [15:0] bias_flips // Bias inversions
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------
    // Panel view: only pulses, no knowledge of setup
    // ------------------------------------------------
    logic [7:0] fcnt;
    logic [7:0] bcnt;
    logic [7:0] lcnt;
    logic last_bias;
    logic flip;
    assign flip = panel.alt_bias_out != last_bias;
    always @(posedge core_clk)
    begin
        last_bias <= panel.alt_bias_out;
        if (srst)
        begin
            {fcnt, bcnt, lcnt, frame_lines, bias_gap, frame_lag, bias_flips} <= '0;
        end
        else
        begin
            bcnt <= (flip ? 8'h0 : bcnt) + {7'h0, panel.line_pulse};
            if (flip)
            begin
                bias_gap <= bcnt;
                bias_flips <= bias_flips + 16'h1;
            end
            if (panel.line_pulse)
            begin
                fcnt <= panel.frame_pulse ? 8'h1 : fcnt + 8'h1;
                lcnt <= line_fetch ? 8'h0 : lcnt + 8'h1;
            end
            if (panel.frame_pulse)
            begin
                frame_lines <= fcnt;
                frame_lag <= lcnt + 8'h1;
            end
        end
    end
endmodule
